// ===== bpif_pkg.sv
// Constants, register map and pin bundle of the BCD parallel input formatter
// ==========================================================================
package bpif_pkg;

   // ========================================================================
   // Register indices
   localparam logic [3:0] REG_BINARY_MODE = 4'h3;
   localparam logic [3:0] REG_STAT_LINES  = 4'h4;
   localparam logic [3:0] REG_STAT_FIRST  = 4'h5;
   localparam logic [3:0] REG_STAT_LAST   = 4'h9;
   localparam logic [7:0] BINARY_MODE_RST = 8'h00;

   // Status register 4 bit positions
   localparam int STAT_SIGN_A_BIT = 0;
   localparam int STAT_SIGN_B_BIT = 1;
   localparam int STAT_OVERLOAD_LINE_BIT   = 2;

   // ========================================================================
   // BCD character codes
   localparam logic [3:0] BCD_LF    = 4'ha;
   localparam logic [3:0] BCD_PLUS  = 4'hb;
   localparam logic [3:0] BCD_COMMA = 4'hc;
   localparam logic [3:0] BCD_MINUS = 4'hd;
   localparam logic [3:0] BCD_EXP   = 4'he;
   localparam logic [3:0] BCD_OVERLOAD_LINE  = 4'h8;
   localparam logic [3:0] BCD_ZERO  = 4'h0;

   // ASCII values
   localparam logic [7:0] ASC_DIGIT_BASE = 8'h30;
   localparam logic [7:0] ASC_LF    = 8'h0a;
   localparam logic [7:0] ASC_PLUS  = 8'h2b;
   localparam logic [7:0] ASC_COMMA = 8'h2c;
   localparam logic [7:0] ASC_MINUS = 8'h2d;
   localparam logic [7:0] ASC_EXP   = 8'h45;
   localparam logic [7:0] ASC_SPACE = 8'h20;

   // Record lengths in characters
   localparam logic [4:0] LEN_BCD_RECORD = 5'd16;
   localparam logic [4:0] LEN_BIN_RECORD = 5'd6;

   // Pin bundle width: forty data lines, two signs, overload
   localparam int PIN_W = 43;

   typedef struct packed {
      logic        overload_line;
      logic        mantissa_sign_b;
      logic        mantissa_sign_a;
      logic [39:0] digit_lines;    // Group n at bits [4n-1:4n-4], weight 8 on top
   } bpif_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_REQUEST = 2'b01,
      ST_STREAM  = 2'b10
   } bpif_state_t;

   typedef enum logic [1:0] {
      FMT_STANDARD = 2'b00,
      FMT_OPTIONAL = 2'b01,
      FMT_BINARY   = 2'b10
   } bpif_fmt_t;

endpackage : bpif_pkg

// ===== bpif_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module bpif_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         meta_ff  <= '0;
         sync_out <= '0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : bpif_sync
`default_nettype wire

// ===== bpif_formatter.sv
// BCD parallel input formatter: handshake, latch, character stream, registers
`timescale 1ns/1ps
`default_nettype none
module bpif_formatter (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Peripheral side
   input  wire bpif_pkg::bpif_pins_t pins_in,
   input  wire logic              peripheral_flag,
   input  wire logic              optional_format_switch,
   output logic                   control_request_a,
   output logic                   control_request_b,
   // Host register port
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   output logic                   reg_rdata_valid,
   // Host character stream
   input  wire logic              enter_start,
   output logic      [7:0]        char_data,
   output logic                   char_valid,
   input  wire logic              char_ready,
   output logic                   busy
);
   import bpif_pkg::*;

   // ========================================================================
   // Pin synchronisers
   logic [PIN_W+1:0] raw_bus;
   logic [PIN_W+1:0] sync_bus;
   bpif_pins_t       pins_s;
   logic             flag_s;
   logic             switch_s;

   assign raw_bus = {optional_format_switch, peripheral_flag, pins_in};

   bpif_sync #(.W(PIN_W + 2)) u_sync (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .async_in (raw_bus),
      .sync_out (sync_bus)
   );

   assign pins_s   = bpif_pins_t'(sync_bus[PIN_W-1:0]);
   assign flag_s   = sync_bus[PIN_W];
   assign switch_s = sync_bus[PIN_W+1];

   // ========================================================================
   // Helpers
   // Four-line group
   function automatic logic [3:0] grp(input logic [39:0] d, input int n);
      grp = d[4*n-1 -: 4];
   endfunction : grp

   function automatic logic [7:0] to_ascii(input logic [3:0] c);
      logic [7:0] r;
      r = ASC_SPACE;
      if (c <= 4'h9) r = ASC_DIGIT_BASE + {4'h0, c};
      else if (c == BCD_LF) r = ASC_LF;
      else if (c == BCD_PLUS) r = ASC_PLUS;
      else if (c == BCD_COMMA) r = ASC_COMMA;
      else if (c == BCD_MINUS) r = ASC_MINUS;
      else if (c == BCD_EXP) r = ASC_EXP;
      to_ascii = r;
   endfunction : to_ascii

   function automatic logic [3:0] sgn(input logic s);
      sgn = s ? BCD_MINUS : BCD_PLUS;
   endfunction : sgn

   // ========================================================================
   // Registers
   bpif_state_t state_ff;
   bpif_fmt_t   fmt_ff;
   bpif_pins_t  latch_ff;
   logic [7:0]  binary_mode_select_ff;
   logic [4:0]  idx_ff;
   logic [7:0]  char_data_ff;
   logic        char_valid_ff;
   logic        req_ff;
   logic        busy_ff;
   logic [7:0]  rdata_ff;
   logic        rvalid_ff;

   assign control_request_a = req_ff;
   assign control_request_b = req_ff;
   assign char_data         = char_data_ff;
   assign char_valid        = char_valid_ff;
   assign busy              = busy_ff;
   assign reg_rdata         = rdata_ff;
   assign reg_rdata_valid   = rvalid_ff;

   // ========================================================================
   // Next character of the current record
   logic [3:0] nxt_code;
   logic [7:0] nxt_char;
   logic [4:0] rec_len;

   always_comb begin
      nxt_code = BCD_LF;
      nxt_char = ASC_LF;
      rec_len  = (fmt_ff == FMT_BINARY) ? LEN_BIN_RECORD : LEN_BCD_RECORD;
      unique case (fmt_ff)
         FMT_OPTIONAL: begin
            unique case (idx_ff)
               5'd0:  nxt_code = sgn(latch_ff.mantissa_sign_a);
               5'd1:  nxt_code = grp(latch_ff.digit_lines, 4);
               5'd2:  nxt_code = grp(latch_ff.digit_lines, 2);
               5'd3:  nxt_code = grp(latch_ff.digit_lines, 6);
               5'd4:  nxt_code = grp(latch_ff.digit_lines, 8);
               5'd5:  nxt_code = BCD_COMMA;
               // Second device, exponent, overload, group 9
               5'd6:  nxt_code = sgn(latch_ff.mantissa_sign_b);
               5'd7:  nxt_code = grp(latch_ff.digit_lines, 10);
               5'd8:  nxt_code = grp(latch_ff.digit_lines, 1);
               5'd9:  nxt_code = grp(latch_ff.digit_lines, 5);
               5'd10: nxt_code = grp(latch_ff.digit_lines, 3);
               5'd11: nxt_code = grp(latch_ff.digit_lines, 7);
               5'd12: nxt_code = BCD_EXP;
               5'd13: nxt_code = latch_ff.overload_line ? BCD_OVERLOAD_LINE : BCD_ZERO;
               5'd14: nxt_code = grp(latch_ff.digit_lines, 9);
               default: nxt_code = BCD_LF;
            endcase
            nxt_char = to_ascii(nxt_code);
         end
         FMT_STANDARD: begin
            unique case (idx_ff)
               5'd0:  nxt_code = sgn(latch_ff.mantissa_sign_a);
               5'd1:  nxt_code = grp(latch_ff.digit_lines, 1);
               5'd2:  nxt_code = grp(latch_ff.digit_lines, 2);
               5'd3:  nxt_code = grp(latch_ff.digit_lines, 3);
               5'd4:  nxt_code = grp(latch_ff.digit_lines, 4);
               5'd5:  nxt_code = grp(latch_ff.digit_lines, 5);
               5'd6:  nxt_code = grp(latch_ff.digit_lines, 6);
               5'd7:  nxt_code = grp(latch_ff.digit_lines, 7);
               5'd8:  nxt_code = grp(latch_ff.digit_lines, 8);
               5'd9:  nxt_code = BCD_EXP;
               5'd10: nxt_code = sgn(latch_ff.mantissa_sign_b);
               5'd11: nxt_code = grp(latch_ff.digit_lines, 9);
               5'd12: nxt_code = BCD_COMMA;
               5'd13: nxt_code = latch_ff.overload_line ? BCD_OVERLOAD_LINE : BCD_ZERO;
               5'd14: nxt_code = grp(latch_ff.digit_lines, 10);
               default: nxt_code = BCD_LF;
            endcase
            nxt_char = to_ascii(nxt_code);
         end
         default: begin
            // Byte pairs in group order, then LF
            unique case (idx_ff)
               5'd0: nxt_char = {grp(latch_ff.digit_lines, 1), grp(latch_ff.digit_lines, 2)};
               5'd1: nxt_char = {grp(latch_ff.digit_lines, 3), grp(latch_ff.digit_lines, 4)};
               5'd2: nxt_char = {grp(latch_ff.digit_lines, 5), grp(latch_ff.digit_lines, 6)};
               5'd3: nxt_char = {grp(latch_ff.digit_lines, 7), grp(latch_ff.digit_lines, 8)};
               5'd4: nxt_char = {grp(latch_ff.digit_lines, 9), grp(latch_ff.digit_lines, 10)};
               default: nxt_char = ASC_LF;
            endcase
         end
      endcase
   end

   // ========================================================================
   // Transfer sequencer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff      <= ST_IDLE;
         fmt_ff        <= FMT_STANDARD;
         latch_ff      <= '0;
         idx_ff        <= 5'd0;
         char_data_ff  <= 8'h00;
         char_valid_ff <= 1'b0;
         req_ff        <= 1'b0;
         busy_ff       <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               // Start only after the previous record is gone
               if (enter_start && !flag_s) begin
                  if (binary_mode_select_ff != 8'h00) fmt_ff <= FMT_BINARY;
                  else if (!switch_s) fmt_ff <= FMT_OPTIONAL;
                  else fmt_ff <= FMT_STANDARD;
                  req_ff   <= 1'b1;
                  busy_ff  <= 1'b1;
                  idx_ff   <= 5'd0;
                  state_ff <= ST_REQUEST;
               end
            end
            ST_REQUEST: begin
               // Flag marks valid data, latch everything
               if (flag_s) begin
                  latch_ff <= pins_s;
                  req_ff   <= 1'b0;
                  state_ff <= ST_STREAM;
               end
            end
            ST_STREAM: begin
               if (!char_valid_ff || char_ready) begin
                  if (idx_ff == rec_len) begin
                     char_valid_ff <= 1'b0;
                     busy_ff       <= 1'b0;
                     state_ff      <= ST_IDLE;
                  end else begin
                     char_data_ff  <= nxt_char;
                     char_valid_ff <= 1'b1;
                     idx_ff        <= idx_ff + 5'd1;
                  end
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ========================================================================
   // Control register write
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         binary_mode_select_ff <= BINARY_MODE_RST;
      end else if (reg_wr && reg_addr == REG_BINARY_MODE) begin
         binary_mode_select_ff <= reg_wdata;
      end
   end

   // ========================================================================
   // Register read, live lines with no handshake
   logic [7:0] nxt_rdata;
   logic [3:0] pair_idx;

   always_comb begin
      nxt_rdata = 8'h00;
      pair_idx  = reg_addr - REG_STAT_FIRST;
      if (reg_addr == REG_BINARY_MODE) begin
         nxt_rdata = binary_mode_select_ff;
      end else if (reg_addr == REG_STAT_LINES) begin
         nxt_rdata[STAT_SIGN_A_BIT] = pins_s.mantissa_sign_a;
         nxt_rdata[STAT_SIGN_B_BIT] = pins_s.mantissa_sign_b;
         nxt_rdata[STAT_OVERLOAD_LINE_BIT]   = pins_s.overload_line;
      end else if (reg_addr >= REG_STAT_FIRST && reg_addr <= REG_STAT_LAST) begin
         // Group pairs, lower group in high nibble
         nxt_rdata = {grp(pins_s.digit_lines, 2 * int'(pair_idx) + 1),
                      grp(pins_s.digit_lines, 2 * int'(pair_idx) + 2)};
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= reg_rd;
         if (reg_rd) rdata_ff <= nxt_rdata;
      end
   end

endmodule : bpif_formatter
`default_nettype wire

// ===== bpif_periph_model.sv
// Behavioural measuring instrument on the far side of the input port
`timescale 1ns/1ps
`default_nettype none
module bpif_periph_model
   import bpif_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       control_request_a,
   input  wire logic       present,
   input  wire bpif_pins_t value,
   input  wire logic [31:0] lag,
   output bpif_pins_t      pins_in,
   output logic            peripheral_flag
);
   // ======================================================================
   // Data and handshake
   int cnt;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pins_in <= '0;
         cnt <= 0;
         peripheral_flag <= 1'b0;
      end else begin
         // Released lines wander while control_request_a and present are both low, so stale data never looks valid
         pins_in <= (control_request_a || present) ? value : ~pins_in;
         cnt <= control_request_a ? cnt + 1 : 0;
         peripheral_flag <= control_request_a && (cnt >= lag);
      end
   end
endmodule : bpif_periph_model
`default_nettype wire

// ===== bpif_formatter_properties.sv
// Port-level checker of the BCD parallel input formatter
`timescale 1ns/1ps
`default_nettype none
module bpif_formatter_properties
   import bpif_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       peripheral_flag,
   input wire logic       control_request_a,
   input wire logic       control_request_b,
   input wire logic       reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rdata_valid,
   input wire logic       enter_start,
   input wire logic [7:0] char_data,
   input wire logic       char_valid,
   input wire logic       char_ready,
   input wire logic       busy
);
   // ======================================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_flag_seen;
      control_request_a && $rose(peripheral_flag);
   endsequence
   property p_req_pair; control_request_a == control_request_b; endproperty
   property p_req_start; $rose(control_request_a) |-> $past(enter_start); endproperty
   property p_no_restart; $rose(control_request_a) |-> !$past(busy); endproperty
   property p_req_hold; control_request_a && !peripheral_flag |=> control_request_a; endproperty
   property p_req_drop; s_flag_seen |-> ##[1:4] !control_request_a; endproperty
   property p_char_hold;
      char_valid && !char_ready |=> char_valid && $stable(char_data);
   endproperty
   property p_rd_valid; 1'b1 |=> reg_rdata_valid == $past(reg_rd); endproperty
   property p_unmapped;
      reg_rd && (reg_addr < 4'h3 || reg_addr > 4'h9) |=> reg_rdata == 8'h00;
   endproperty
   property p_lf_end; $fell(busy) |-> $past(char_data) == ASC_LF; endproperty
   property p_idle_quiet; !busy |-> !char_valid; endproperty
   a_req_pair: assert property (p_req_pair) else $error("requests differ");
   a_req_start: assert property (p_req_start) else $error("request without start");
   a_no_restart: assert property (p_no_restart) else $error("request while busy");
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   a_req_drop: assert property (p_req_drop) else $error("request not dropped");
   a_char_hold: assert property (p_char_hold) else $error("char not held");
   a_rd_valid: assert property (p_rd_valid) else $error("read answer timing");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_lf_end: assert property (p_lf_end) else $error("record not ended by LF");
   a_idle_quiet: assert property (p_idle_quiet) else $error("char while idle");
endmodule : bpif_formatter_properties
bind bpif_formatter bpif_formatter_properties bpif_formatter_properties_i (.clk_sys,
   .reset, .peripheral_flag, .control_request_a, .control_request_b, .reg_rd, .reg_addr,
   .reg_rdata, .reg_rdata_valid, .enter_start, .char_data, .char_valid, .char_ready, .busy);
`default_nettype wire

// ===== bpif_formatter_tb.sv
// Self-checking testbench of the BCD parallel input formatter
`timescale 1ns/1ps
`default_nettype none
module bpif_formatter_tb;
   import bpif_pkg::*;
   logic       clk_sys = 0, reset = 1, optional_format_switch = 0, present = 0;
   logic       reg_wr = 0, reg_rd = 0, enter_start = 0, char_ready = 0;
   logic       control_request_a, control_request_b, reg_rdata_valid, char_valid, busy;
   logic       peripheral_flag;
   logic [3:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, char_data, mv, q[$];
   logic [31:0] st = 32'd17522;
   bpif_pins_t pins_in, pv = '0;
   int         lag = 3, m, miscompares = 0, checks = 0;
   int         o1[4] = '{4, 2, 6, 8};
   int         o2[5] = '{10, 1, 5, 3, 7};
   always #5 clk_sys = ~clk_sys;
   bpif_formatter bpif_formatter_i (.clk_sys, .reset, .pins_in, .peripheral_flag,
      .optional_format_switch, .control_request_a, .control_request_b, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .reg_rdata_valid, .enter_start, .char_data,
      .char_valid, .char_ready, .busy);
   bpif_periph_model bpif_periph_model_i (.clk_sys, .reset, .control_request_a, .present,
      .value(pv), .lag, .pins_in, .peripheral_flag);
   // ======================================================================
   // Helpers
   function automatic logic [31:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction : xs
   function automatic logic [7:0] dg(input int n);
      return ASC_DIGIT_BASE + 8'(pv.digit_lines[4*n-4 +: 4]);
   endfunction : dg
   function automatic logic [7:0] sg(input logic b);
      return b ? ASC_MINUS : ASC_PLUS;
   endfunction : sg
   task automatic end_of_test();
      // Expected results never produced count as one mismatch
      if (q.size() != 0) begin
         miscompares++;
         $display("unexpected at %0t: %h results left, expected %h", $time, q.size(), 0);
      end
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [7:0] got);
      logic [7:0] e;
      e = (q.size() > 0) ? q.pop_front() : 8'hxx;
      checks++;
      if (got !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, e);
      end
   endtask : cmp
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge clk_sys);
      reg_wr = 0;
      @(negedge clk_sys);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      q.push_back(e);
      reg_addr = a;
      reg_rd = 1;
      @(negedge clk_sys);
      reg_rd = 0;
      @(negedge clk_sys);
   endtask : rd
   task automatic rec(input int fm);
      int i;
      if (fm == 2) begin
         for (i = 0; i < 5; i++)
            q.push_back({pv.digit_lines[8*i +: 4], pv.digit_lines[8*i+4 +: 4]});
      end else if (fm == 1) begin
         q.push_back(sg(pv.mantissa_sign_a));
         foreach (o1[j]) q.push_back(dg(o1[j]));
         q.push_back(ASC_COMMA);
         q.push_back(sg(pv.mantissa_sign_b));
         foreach (o2[j]) q.push_back(dg(o2[j]));
         q.push_back(ASC_EXP);
         q.push_back(pv.overload_line ? 8'h38 : 8'h30);
         q.push_back(dg(9));
      end else begin
         q.push_back(sg(pv.mantissa_sign_a));
         for (i = 1; i < 9; i++) q.push_back(dg(i));
         q.push_back(ASC_EXP);
         q.push_back(sg(pv.mantissa_sign_b));
         q.push_back(dg(9));
         q.push_back(ASC_COMMA);
         q.push_back(pv.overload_line ? 8'h38 : 8'h30);
         q.push_back(dg(10));
      end
      q.push_back(ASC_LF);
      enter_start = 1;
      @(negedge clk_sys);
      enter_start = 0;
      for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys);
      if (i == 400) begin
         miscompares++;
         $display("unexpected at %0t: busy %h expected %h", $time, busy, 1'b0);
      end
   endtask : rec
   // ======================================================================
   // Stimulus, monitor and watchdog
   always @(negedge clk_sys) char_ready <= xs() > 32'h50000000;
   always @(posedge clk_sys) begin
      if ((char_valid & char_ready) === 1'b1) cmp(char_data);
      if (reg_rdata_valid === 1'b1) cmp(reg_rdata);
   end
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (12) @(negedge clk_sys);
      reset = 0;
      for (int t = 0; t < 6; t++) begin
         m = t % 3;
         for (int n = 0; n < 40; n += 4)
            pv.digit_lines[n +: 4] = (m == 2) ? 4'(xs()) : 4'(xs() % 10);
         {pv.overload_line, pv.mantissa_sign_b, pv.mantissa_sign_a} = 3'(xs());
         mv = (m == 2) ? {7'(xs()), 1'b1} : 8'h00;
         optional_format_switch = (m == 0) || (t == 5);
         lag = 3 + int'(xs() % 6);
         wr(REG_BINARY_MODE, mv);
         rd(REG_BINARY_MODE, mv);
         rec(m);
         present = 1;
         repeat (4) @(negedge clk_sys);
         mv = {5'h00, pv.overload_line, pv.mantissa_sign_b, pv.mantissa_sign_a};
         rd(REG_STAT_LINES, mv);
         for (int k = 0; k < 5; k++) begin
            mv = {pv.digit_lines[8*k +: 4], pv.digit_lines[8*k+4 +: 4]};
            rd(REG_STAT_FIRST + 4'(k), mv);
         end
         rd(4'hf, 8'h00);
         present = 0;
         $display("test %0d done", t);
      end
      repeat (5) @(negedge clk_sys);
      end_of_test();
   end
endmodule : bpif_formatter_tb
`default_nettype wire
